// *** src/dsec_params.svh ***
// Register offsets, field positions, reset values and timing for the error counter block
`ifndef DSEC_PARAMS_SVH
`define DSEC_PARAMS_SVH

// Register byte offsets
`define DSEC_OFS_XBIT      8'h00
`define DSEC_OFS_FRAME     8'h04
`define DSEC_OFS_PATH      8'h08
`define DSEC_OFS_FAR_END_BLOCK_ERROR_COUNT      8'h0c
`define DSEC_OFS_EXZ       8'h10
`define DSEC_OFS_LCV       8'h14
`define DSEC_OFS_ONESEC    8'h18
`define DSEC_OFS_CTRL      8'h1c
`define DSEC_OFS_GCTRL2    8'h20
`define DSEC_OFS_CNTSTAT   8'h24
`define DSEC_OFS_SRCSTAT   8'h28

// Counter widths and saturation limits
`define DSEC_NUM_CNT       6
`define DSEC_LCV_IDX       5
`define DSEC_MAX16         24'h00ffff
`define DSEC_MAX24         24'hffffff

// One-second timer
`define DSEC_ONESEC_W      26
`define DSEC_ONESEC_RST    26'h2aa9e00

// Channel control fields
`define DSEC_CTRL_EN       0
`define DSEC_CTRL_FMT_LO   1
`define DSEC_CTRL_ZSUB     3
`define DSEC_CTRL_IE_LO    4

// General control two fields
`define DSEC_GC2_LATCH     0
`define DSEC_GC2_INTTRIG   1
`define DSEC_GC2_IVLIE     2

`endif

// *** src/dsec_pkg.sv ***
// Types shared by the error counter block
package dsec_pkg;

	// Framing format of the channel
	typedef enum logic [1:0]
	{
		FMT_M13  = 2'h0,
		FMT_CBIT = 2'h1,
		FMT_G751 = 2'h2,
		FMT_G832 = 2'h3
	} dsec_fmt_t;

	// Bus slave phase, one-hot
	typedef enum logic [2:0]
	{
		PH_IDLE = 3'h1,
		PH_WAIT = 3'h2,
		PH_DONE = 3'h4
	} dsec_phase_t;

	// APB request from the master
	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dsec_apb_req_t;

	// Event pulses from the channel receiver
	typedef struct packed
	{
		logic xBitDisagree;
		logic framePatternError;
		logic pathParityError;
		logic subframe4CbitZero;
		logic reiBitSet;
		logic excessZeros;
		logic lineCodeViolation;
	} dsec_events_t;

	// Whole state of the block
	typedef struct packed
	{
		logic [5:0][23:0] cnt;
		logic [5:0]       cntStatus;
		logic             chanEnable;
		dsec_fmt_t        format;
		logic             zeroSubst;
		logic [5:0]       cntIntEn;
		logic             latchMode;
		logic             internalTrig;
		logic             intervalIe;
		logic             intervalFlag;
		logic [25:0]      reload;
		logic [25:0]      live;
		logic [2:0]       txSync;
		logic             enPrev;
		dsec_phase_t      phase;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             irqN;
	} dsec_state_t;

endpackage : dsec_pkg

// *** src/dsec_counters.sv ***
// Error counters and one-second interval timer of one framer channel
//
// How it works
// [R1] Count frames whose two X-bits differ
// [R2] Count framing bit or alignment pattern errors
// [R3] Frame errors still counted during out-of-frame
// [R4] Count path parity versus C-bit majority mismatches
// [R5] C-bit mode: count subframe 4 zero C-bits
// [R6] G.832 mode: count REI frames; M13 and G.751 idle
// [R7] Excess zeros counted only with zero substitution
// [R8] Line code violation counter is 24 bits
// [R9] Counters zero after reset and channel enable
// [R10] Timer decrements per transmit clock, rolls at zero
// [R11] Timer resets to default one-second count
// [R12] Rollover reloads programmed count and continues
// [R13] Timer read returns live count
// [R14] Channel enable restarts timer from reload value
// [R15] Timer write clears latching mode bit
// [R16] Internal trigger: rollover sets interval flag
// [R17] Flag with enable drives interrupt low
// [R18] Interrupt off: saturate, flag, clear on read
// [R19] Interrupt on: wrap to zero and interrupt
// [R20] Read clears counter without losing events
// [R21] Software reads low byte first; here each register reads as one 32-bit word
// [R22] Timer upper six bits read zero
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dsec_params.svh"

module dsec_counters
(
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	// Register bus
	input  wire dsec_pkg::dsec_apb_req_t apbReq,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr,
	// Receiver events and transmit clock pin
	input  wire dsec_pkg::dsec_events_t eventsIn,
	input  wire logic                   transmit_clock_in,
	// Interrupt pin
	output logic                        interrupt_out_n
);

	// Register state and its next value
	dsec_pkg::dsec_state_t st;
	dsec_pkg::dsec_state_t next_st;
	// Per-counter increment requests after mode gating
	logic [5:0]            incReq;
	// Rising edge of transmit clock seen on the synchronised copy
	logic                  txTick;
	// Rising edge of channel enable
	logic                  enRise;
	// Decoded counter address: hit flag above a three-bit index
	logic [3:0]            counterDec;
	// Counter address hit by the current request, and its index
	logic                  counterHit;
	logic [2:0]            counterIdx;

	// Saturation limit of a counter
	function automatic logic [23:0] limitOf(input logic [2:0] idx);
		limitOf = (idx == 3'(`DSEC_LCV_IDX)) ? `DSEC_MAX24 : `DSEC_MAX16;
	endfunction : limitOf

	// One count step: returns overflow indication and new value
	function automatic logic [24:0] stepCount
	(
		input logic [23:0] val,
		input logic [23:0] lim,
		input logic        inc,
		input logic        wrapEn
	);
		if (!inc)
			stepCount = {1'b0, val};
		else if (val == lim)
			stepCount = wrapEn ? {1'b1, 24'h000000} : {1'b1, lim}; // [R18] [R19]
		else
			stepCount = {1'b0, val + 24'h000001};
	endfunction : stepCount

	// Map a byte address onto a counter index
	function automatic logic [3:0] decodeCounter(input logic [7:0] addr);
		case (addr)
			`DSEC_OFS_XBIT:  decodeCounter = 4'h8;
			`DSEC_OFS_FRAME: decodeCounter = 4'h9;
			`DSEC_OFS_PATH:  decodeCounter = 4'ha;
			`DSEC_OFS_FAR_END_BLOCK_ERROR_COUNT:  decodeCounter = 4'hb;
			`DSEC_OFS_EXZ:   decodeCounter = 4'hc;
			`DSEC_OFS_LCV:   decodeCounter = 4'hd;
			default:         decodeCounter = 4'h0;
		endcase
	endfunction : decodeCounter

	// Event gating by framing format and line coding
	always_comb
	begin
		incReq[0] = eventsIn.xBitDisagree;                                   // [R1]
		incReq[1] = eventsIn.framePatternError;                              // [R2] [R3]
		incReq[2] = eventsIn.pathParityError;                                // [R4]
		incReq[3] = ((st.format == dsec_pkg::FMT_CBIT) && eventsIn.subframe4CbitZero)
			|| ((st.format == dsec_pkg::FMT_G832) && eventsIn.reiBitSet);    // [R5] [R6]
		incReq[4] = st.zeroSubst && eventsIn.excessZeros;                    // [R7]
		incReq[5] = eventsIn.lineCodeViolation;                              // [R8]
		txTick     = st.txSync[1] && !st.txSync[2];
		enRise     = st.chanEnable && !st.enPrev;
		// Decode once, then split into hit flag and index
		counterDec = decodeCounter(apbReq.paddr);
		counterHit = counterDec[3];
		counterIdx = counterDec[2:0];
	end

	// Next state of the whole block
	always_comb
	begin
		logic [24:0] stepRes;
		logic [23:0] base;
		logic        readClr;
		logic        wrEdge;
		logic        rolled;
		next_st = st;
		stepRes = 25'h0000000;
		base    = 24'h000000;
		readClr = 1'b0;
		wrEdge  = 1'b0;
		rolled  = 1'b0;
		// Pin synchroniser, first stage read only by the second
		next_st.txSync = {st.txSync[1:0], transmit_clock_in};
		next_st.enPrev = st.chanEnable;

		// Bus phase: one wait cycle, answer registered
		case (st.phase)
			dsec_pkg::PH_IDLE:
			begin
				if (apbReq.psel && apbReq.penable)
					next_st.phase = dsec_pkg::PH_WAIT;
			end
			dsec_pkg::PH_WAIT:
			begin
				// Capture read data and do clear-on-read here
				next_st.phase   = dsec_pkg::PH_DONE;
				next_st.pready  = 1'b1;
				next_st.pslverr = 1'b0;
				next_st.prdata  = 32'h00000000;
				readClr         = !apbReq.pwrite;
				case (apbReq.paddr)
					`DSEC_OFS_XBIT, `DSEC_OFS_FRAME, `DSEC_OFS_PATH,
					`DSEC_OFS_FAR_END_BLOCK_ERROR_COUNT, `DSEC_OFS_EXZ, `DSEC_OFS_LCV:
						next_st.prdata = {8'h00, st.cnt[counterIdx]};
					`DSEC_OFS_ONESEC:
						next_st.prdata = {6'h00, st.live};                 // [R13] [R22]
					`DSEC_OFS_CTRL:
						next_st.prdata = {22'h000000, st.cntIntEn, st.zeroSubst, st.format, st.chanEnable};
					`DSEC_OFS_GCTRL2:
						next_st.prdata = {29'h00000000, st.intervalIe, st.internalTrig, st.latchMode};
					`DSEC_OFS_CNTSTAT:
						next_st.prdata = {26'h0000000, st.cntStatus};
					`DSEC_OFS_SRCSTAT:
						next_st.prdata = {31'h00000000, st.intervalFlag};
					default:
						next_st.pslverr = 1'b1;
				endcase
			end
			dsec_pkg::PH_DONE:
			begin
				// Transfer completes at this edge
				next_st.phase  = dsec_pkg::PH_IDLE;
				next_st.pready = 1'b0;
				next_st.pslverr = 1'b0;
				wrEdge         = apbReq.pwrite;
			end
			default:
				next_st.phase = dsec_pkg::PH_IDLE;
		endcase

		// Error counters: event, saturation, wrap and clear-on-read
		for (int i = 0; i < `DSEC_NUM_CNT; i++)
		begin
			// A read clears to zero and the event of that cycle still counts
			base = (readClr && counterHit && counterIdx == 3'(i)) ? 24'h000000 : st.cnt[i]; // [R20]
			stepRes = stepCount(base, limitOf(3'(i)), incReq[i], st.cntIntEn[i]);
			next_st.cnt[i] = stepRes[23:0];
			if (stepRes[24])
				next_st.cntStatus[i] = 1'b1;                                 // [R18] [R19]
		end
		// Status read clears, but a new indication of the same cycle wins
		if (readClr && apbReq.paddr == `DSEC_OFS_CNTSTAT)
			for (int i = 0; i < `DSEC_NUM_CNT; i++)
				next_st.cntStatus[i] = next_st.cntStatus[i] && (st.cnt[i] == limitOf(3'(i))) && incReq[i]; // [R18]

		// One-second timer on transmit clock edges
		if (enRise)
			next_st.live = st.reload;                                        // [R14]
		else if (txTick)
		begin
			if (st.live == 26'h0000000)
			begin
				next_st.live = st.reload;                                    // [R10] [R12]
				rolled       = 1'b1;
			end
			else
				next_st.live = st.live - 26'h0000001;                        // [R10]
		end

		// Register writes at the completing edge
		if (wrEdge)
		begin
			case (apbReq.paddr)
				`DSEC_OFS_XBIT, `DSEC_OFS_FRAME, `DSEC_OFS_PATH,
				`DSEC_OFS_FAR_END_BLOCK_ERROR_COUNT, `DSEC_OFS_EXZ:
					next_st.cnt[counterIdx] = {8'h00, apbReq.pwdata[15:0]};
				`DSEC_OFS_LCV:
					next_st.cnt[counterIdx] = apbReq.pwdata[23:0];
				`DSEC_OFS_ONESEC:
				begin
					next_st.reload    = apbReq.pwdata[25:0];
					next_st.latchMode = 1'b0;                                // [R15]
				end
				`DSEC_OFS_CTRL:
				begin
					next_st.chanEnable = apbReq.pwdata[`DSEC_CTRL_EN];
					next_st.format     = dsec_pkg::dsec_fmt_t'(apbReq.pwdata[`DSEC_CTRL_FMT_LO +: 2]);
					next_st.zeroSubst  = apbReq.pwdata[`DSEC_CTRL_ZSUB];
					next_st.cntIntEn   = apbReq.pwdata[`DSEC_CTRL_IE_LO +: 6];
				end
				`DSEC_OFS_GCTRL2:
				begin
					next_st.latchMode    = apbReq.pwdata[`DSEC_GC2_LATCH];
					next_st.internalTrig = apbReq.pwdata[`DSEC_GC2_INTTRIG];
					next_st.intervalIe   = apbReq.pwdata[`DSEC_GC2_IVLIE];
				end
				default:
					next_st.phase = dsec_pkg::PH_IDLE;
			endcase
		end

		// Channel enable clears all counters
		if (enRise)
			next_st.cnt = '0;                                                // [R9]

		// Interval flag: read clears, a rollover of the same cycle wins
		if (readClr && apbReq.paddr == `DSEC_OFS_SRCSTAT)
			next_st.intervalFlag = 1'b0;
		if (rolled && st.internalTrig)
			next_st.intervalFlag = 1'b1;                                     // [R16]

		// Interrupt pin from current status
		next_st.irqN = !((st.intervalFlag && st.intervalIe)
			|| ((st.cntStatus & st.cntIntEn) != 6'h00));                    // [R17] [R19]
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st              <= '0;
			st.format       <= dsec_pkg::FMT_M13;
			st.reload       <= `DSEC_ONESEC_RST;                             // [R11]
			st.live         <= `DSEC_ONESEC_RST;                             // [R11]
			st.phase        <= dsec_pkg::PH_IDLE;
			st.irqN         <= 1'b1;
		end
		else
			st <= next_st;
	end

	// Outputs straight from flops
	assign pready          = st.pready;
	assign prdata          = st.prdata;
	assign pslverr         = st.pslverr;
	assign interrupt_out_n = st.irqN;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// Completing write edge, for the checks
	logic wrEdgeChk;
	assign wrEdgeChk = st.phase == dsec_pkg::PH_DONE && apbReq.pwrite;
	// No read, write or enable restart can touch a counter this cycle
	logic cntFree;
	assign cntFree = !(st.phase == dsec_pkg::PH_WAIT) && !wrEdgeChk && !enRise;

	// Read of the timer in its wait cycle
	sequence readWaitT;
		st.phase == dsec_pkg::PH_WAIT && !apbReq.pwrite && apbReq.paddr == `DSEC_OFS_ONESEC;
	endsequence

	// Read of a counter in its wait cycle
	sequence readWaitX;
		st.phase == dsec_pkg::PH_WAIT && !apbReq.pwrite && apbReq.paddr == `DSEC_OFS_XBIT;
	endsequence
	// Transmit clock edge seen while timer running
	sequence tickNonZero;
		txTick && !enRise && st.live != 26'h0000000;
	endsequence

	chk_read_clears: assert property (readWaitX and !incReq[0] |=> st.cnt[0] == 24'h000000) // [R20]
		else $error("Counter not cleared by read");
	chk_read_keeps: assert property (readWaitX and incReq[0] |=> st.cnt[0] == 24'h000001) // [R20]
		else $error("Event lost during read");
	chk_read_value: assert property (readWaitX |=> prdata == {8'h00, $past(st.cnt[0])} ##1 !pready) // [R20]
		else $error("Read value or answer timing wrong");
	chk_sat_hold: assert property (st.cnt[5] == `DSEC_MAX24 && incReq[5] && !st.cntIntEn[5]
		&& !(st.phase == dsec_pkg::PH_WAIT) && !wrEdgeChk && !enRise
		|=> st.cnt[5] == `DSEC_MAX24 && st.cntStatus[5]) // [R18]
		else $error("Saturation failed");
	chk_wrap_zero: assert property (st.cnt[0] == `DSEC_MAX16 && incReq[0] && st.cntIntEn[0] // [R19]
		&& !(st.phase == dsec_pkg::PH_WAIT) && !wrEdgeChk && !enRise
		|=> st.cnt[0] == 24'h000000 && st.cntStatus[0] ##1 !interrupt_out_n)
		else $error("Wrap or its interrupt failed");
	chk_tick_dec: assert property (tickNonZero |=> st.live == $past(st.live) - 26'h0000001) // [R10]
		else $error("Timer did not decrement");
	chk_reload_roll: assert property (txTick && !enRise && st.live == 26'h0000000 && st.internalTrig
		|=> st.live == $past(st.reload) && st.intervalFlag) // [R12] [R16]
		else $error("Rollover reload or flag failed");
	chk_write_latch: assert property (st.phase == dsec_pkg::PH_DONE && apbReq.pwrite
		&& apbReq.paddr == `DSEC_OFS_ONESEC |=> !st.latchMode) // [R15]
		else $error("Latching mode not cleared");
	chk_irq_flag: assert property (st.intervalFlag && st.intervalIe |=> !interrupt_out_n) // [R17]
		else $error("Interval interrupt missing");
	chk_enable_clear: assert property (enRise |=> st.cnt == '0 && st.live == $past(st.reload)) // [R9] [R14]
		else $error("Enable did not restart counters");
	chk_exz_gate: assert property (!st.zeroSubst && !(st.phase == dsec_pkg::PH_DONE) && !enRise // [R7]
		|=> st.cnt[4] == $past(st.cnt[4]) || $past(st.phase == dsec_pkg::PH_WAIT))
		else $error("Excess zeros counted without substitution");

	// Unused far-end block error counter stays put
	chk_far_end_block_error_count_idle: assert property ((st.format == dsec_pkg::FMT_M13 || st.format == dsec_pkg::FMT_G751) // [R6]
		&& !(st.phase == dsec_pkg::PH_DONE) && !enRise
		|=> st.cnt[3] == $past(st.cnt[3]) || $past(st.phase == dsec_pkg::PH_WAIT))
		else $error("Far-end block errors counted in an unused mode");

	// Plain count steps below the limit, no bus access or restart in the way
	chk_xbit_step: assert property (st.cnt[0] != `DSEC_MAX16 && incReq[0] && cntFree // [R1]
		|=> st.cnt[0] == $past(st.cnt[0]) + 24'h000001)
		else $error("X-bit disagreement not counted");
	chk_frame_step: assert property (st.cnt[1] != `DSEC_MAX16 && incReq[1] && cntFree // [R2] [R3]
		|=> st.cnt[1] == $past(st.cnt[1]) + 24'h000001)
		else $error("Frame error not counted");
	chk_path_step: assert property (st.cnt[2] != `DSEC_MAX16 && incReq[2] && cntFree // [R4]
		|=> st.cnt[2] == $past(st.cnt[2]) + 24'h000001)
		else $error("Path parity error not counted");
	chk_far_end_block_error_count_step: assert property (st.cnt[3] != `DSEC_MAX16 && incReq[3] && cntFree // [R5] [R6]
		|=> st.cnt[3] == $past(st.cnt[3]) + 24'h000001)
		else $error("Far-end block error not counted");
	chk_exz_step: assert property (st.cnt[4] != `DSEC_MAX16 && incReq[4] && cntFree // [R7]
		|=> st.cnt[4] == $past(st.cnt[4]) + 24'h000001)
		else $error("Excess zeros not counted");
	chk_lcv_step: assert property (st.cnt[5] != `DSEC_MAX24 && incReq[5] && cntFree // [R8]
		|=> st.cnt[5] == $past(st.cnt[5]) + 24'h000001)
		else $error("Line code violation not counted");

	// Timer moves only on a transmit clock edge or a restart
	chk_timer_hold: assert property (!txTick && !enRise |=> st.live == $past(st.live)) // [R10]
		else $error("Timer moved without a transmit clock edge");
	// Timer read returns the live count with zero upper bits
	chk_timer_read: assert property (readWaitT |=> prdata == {6'h00, $past(st.live)}) // [R13] [R22]
		else $error("Timer read value wrong");

	// No pending source keeps the interrupt pin high
	chk_irq_quiet: assert property (!(st.intervalFlag && st.intervalIe) // [R17]
		&& ((st.cntStatus & st.cntIntEn) == 6'h00) |=> interrupt_out_n)
		else $error("Interrupt asserted with no source");
	// A source status read clears the interval flag when no rollover competes
	chk_flag_clear: assert property (st.phase == dsec_pkg::PH_WAIT && !apbReq.pwrite // [R16]
		&& apbReq.paddr == `DSEC_OFS_SRCSTAT && !(txTick && st.live == 26'h0000000)
		|=> !st.intervalFlag)
		else $error("Interval flag not cleared by read");

endmodule : dsec_counters

`default_nettype wire

// *** sim/dsec_rx_model.sv ***
// Receiver stand-in: event pulses and a gated transmit clock
`timescale 1ns/1ps
`default_nettype none

module dsec_rx_model
(
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	// Requests from the bench
	input  wire dsec_pkg::dsec_events_t pulseReq,
	input  wire logic                   txRun,
	// Toward the block, and an edge count for the bench
	output var dsec_pkg::dsec_events_t  eventsOut,
	output var logic                    txClk,
	output var logic [7:0]              ticks
);
	logic [2:0] phase; // Position in the transmit clock period

	// One pulse per requested cycle, launched on the block's clock
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			eventsOut <= '0;
		else
			eventsOut <= pulseReq;
	end

	// Four cycles low, four high; parked low between runs
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			phase <= 3'h0;
			ticks <= 8'h00;
		end
		else if (txRun || phase != 3'h0)
		begin
			phase <= phase + 3'h1;
			if (phase == 3'h3)
				ticks <= ticks + 8'h01;
		end
	end

	// Clock level follows the top phase bit
	assign txClk = phase[2];
endmodule : dsec_rx_model
`default_nettype wire

// *** sim/test_ds3_e3_error_counters_onesec.sv ***
// Self-checking bench for the error counters and interval timer
`timescale 1ns/1ps
`default_nettype none
`include "dsec_params.svh"

module test_ds3_e3_error_counters_onesec;
	logic                    ref_clk;   // Bench clock
	logic                    nrst;      // Reset, active low
	dsec_pkg::dsec_apb_req_t req;       // Bus request
	logic                    pready;    // Transfer done
	logic [31:0]             prdata;    // Read data
	logic                    pslverr;   // Error answer
	dsec_pkg::dsec_events_t  pulseReq;  // Events asked of the receiver
	dsec_pkg::dsec_events_t  events;    // Events into the block
	logic                    txRun;     // Transmit clock gate
	logic                    txClk;     // Transmit clock
	logic [7:0]              ticks;     // Transmit edges sent
	logic                    irqN;      // Interrupt pin
	logic [31:0]             seed;      // Random state
	logic [31:0]             rd;        // Last read data
	logic                    er;        // Last error answer
	int                      err_total; // Mismatches
	int                      n_checks;  // Comparisons
	int                      expCnt[6]; // Model counters
	int                      fmt;       // Model format
	int                      zs;        // Model zero substitution
	int                      live;      // Model timer

	// Block under test
	dsec_counters dut (.ref_clk(ref_clk), .nrst(nrst), .apbReq(req), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .eventsIn(events), .transmit_clock_in(txClk), .interrupt_out_n(irqN));

	// Far side model
	dsec_rx_model rx (.ref_clk(ref_clk), .nrst(nrst), .pulseReq(pulseReq), .txRun(txRun),
		.eventsOut(events), .txClk(txClk), .ticks(ticks));

	// Clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Xorshift step
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	// Compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One bus transfer; whole words are read, low bytes with the rest
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge ref_clk);
		req.penable <= 1'b1;
		// Sample pready at each rising edge; the answer is taken at the edge that sees it high
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1)
			err_total++;
		rd = prdata;
		er = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	// Read and compare
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk

	// Event cycles: random bits under mask plus forced bits, tracked by the model
	task automatic burst(input int n, input logic [6:0] mask, input logic [6:0] frc);
		logic [6:0] v;
		repeat (n)
		begin
			@(posedge ref_clk);
			seed = xs(seed);
			v = (seed[6:0] & mask) | frc;
			pulseReq <= dsec_pkg::dsec_events_t'(v);
			expCnt[0] += v[6];
			expCnt[1] += v[5];
			expCnt[2] += v[4];
			expCnt[3] += ((fmt == 1) && v[3]) || ((fmt == 3) && v[2]);
			expCnt[4] += (zs == 1) && v[1];
			expCnt[5] += v[0];
		end
		@(posedge ref_clk);
		pulseReq <= '0;
		repeat (4) @(posedge ref_clk);
	endtask : burst

	// Watchdog
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		req = '0;
		pulseReq = '0;
		txRun = 1'b0;
		nrst = 1'b0;
		seed = 32'd40106;
		err_total = 0;
		n_checks = 0;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		// Values after reset
		for (int i = 0; i < 7; i++)
			rdchk(8'(4 * i), (i == 6) ? 32'h02aa9e00 : 32'h0);
		apb(1'b0, 8'h2c, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		// Every format, zero substitution on and off
		for (fmt = 0; fmt < 4; fmt++)
		begin
			zs = fmt % 2;
			apb(1'b1, `DSEC_OFS_CTRL, 32'(1 | (fmt << 1) | (zs << 3)));
			burst(60, 7'h7f, 7'h00);
			for (int i = 0; i < 6; i++)
			begin
				rdchk(8'(4 * i), 32'(expCnt[i]));
				expCnt[i] = 0;
			end
		end
		// Enable restart clears counters
		burst(5, 7'h00, 7'h7f);
		apb(1'b1, `DSEC_OFS_CTRL, 32'h0);
		apb(1'b1, `DSEC_OFS_CTRL, 32'h1);
		for (int i = 0; i < 6; i++)
			rdchk(8'(4 * i), 32'h0);
		// Saturation with interrupts off
		apb(1'b1, `DSEC_OFS_XBIT, 32'hfffe);
		apb(1'b1, `DSEC_OFS_LCV, 32'hfffffe);
		burst(3, 7'h00, 7'h41);
		rdchk(`DSEC_OFS_XBIT, 32'hffff);
		rdchk(`DSEC_OFS_LCV, 32'hffffff);
		rdchk(`DSEC_OFS_CNTSTAT, 32'h21);
		rdchk(`DSEC_OFS_CNTSTAT, 32'h0);
		chk(irqN, 1'b1);
		// Wrap with the first counter's interrupt on
		apb(1'b1, `DSEC_OFS_CTRL, 32'h11);
		apb(1'b1, `DSEC_OFS_XBIT, 32'hffff);
		burst(1, 7'h00, 7'h40);
		chk(irqN, 1'b0);
		rdchk(`DSEC_OFS_XBIT, 32'h0);
		rdchk(`DSEC_OFS_CNTSTAT, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk(irqN, 1'b1);
		// Interval timer
		apb(1'b1, `DSEC_OFS_GCTRL2, 32'h7);
		apb(1'b1, `DSEC_OFS_ONESEC, 32'h5);
		rdchk(`DSEC_OFS_GCTRL2, 32'h6);
		apb(1'b1, `DSEC_OFS_CTRL, 32'h0);
		apb(1'b1, `DSEC_OFS_CTRL, 32'h1);
		rdchk(`DSEC_OFS_ONESEC, 32'h5);
		@(posedge ref_clk);
		txRun <= 1'b1;
		for (int n = 0; n < 200 && ticks < 8'd8; n++)
			@(negedge ref_clk);
		@(posedge ref_clk);
		txRun <= 1'b0;
		repeat (20) @(posedge ref_clk);
		live = 5;
		repeat (ticks)
			live = (live == 0) ? 5 : live - 1;
		rdchk(`DSEC_OFS_ONESEC, 32'(live));
		chk(irqN, 1'b0);
		rdchk(`DSEC_OFS_SRCSTAT, 32'h1);
		rdchk(`DSEC_OFS_SRCSTAT, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk(irqN, 1'b1);
		report_and_stop();
	end
endmodule : test_ds3_e3_error_counters_onesec
`default_nettype wire
